// ### include/irq_wake_pkg.sv
// Constants and types shared by the interrupt and wake-up vectoring unit
package irq_wake_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned IRQ_RATE_HZ = 32768;
  localparam int unsigned IRQ_PERIOD_CYCLES = CLK_HZ / IRQ_RATE_HZ;
  localparam int unsigned WAKE_BASE_MS = 1;
  localparam int unsigned WAKE_BASE_CYCLES = WAKE_BASE_MS * (CLK_HZ / 1000);
  localparam int unsigned DIV_W = 17;
  localparam int unsigned WAKE_STABLE_CYCLES = 64;
  localparam logic [6:0] WAKE_STABLE_LAST = 7'(WAKE_STABLE_CYCLES - 1);
  // Wake-up periods in base ticks, per select code 00/01/10/11
  localparam logic [7:0] WAKE_MS_SEL0 = 8'h01;
  localparam logic [7:0] WAKE_MS_SEL1 = 8'h10;
  localparam logic [7:0] WAKE_MS_SEL2 = 8'h40;
  localparam logic [7:0] WAKE_MS_SEL3 = 8'h80;
  // Vectors
  localparam int unsigned PC_W = 13;
  localparam logic [12:0] VEC_RESET = 13'h000;
  localparam logic [12:0] VEC_WAKE = 13'h004;
  localparam logic [12:0] VEC_IRQ = 13'h008;
  // Register indices; byte address is index times four
  localparam int unsigned ADDR_W = 8;
  localparam logic [5:0] IDX_STATUS = 6'h00;
  localparam logic [5:0] IDX_PWM_CTRL = 6'h09;
  localparam logic [5:0] IDX_WAKE_CTRL = 6'h16;
  localparam logic [5:0] IDX_ROM_HI = 6'h1d;
  // Field positions
  localparam int unsigned STAT_IRQ_BIT = 2;
  localparam int unsigned STAT_CARRY_BIT = 1;
  localparam int unsigned STAT_ZERO_BIT = 0;
  localparam int unsigned CTRL_IRQ_EN_BIT = 1;
  localparam int unsigned CTRL_PWM_EN_BIT = 0;
  localparam int unsigned WAKE_FLAG_BIT = 3;
  localparam int unsigned WAKE_EN_BIT = 2;
  localparam int unsigned WAKE_SEL_HI = 1;
  localparam int unsigned WAKE_SEL_LO = 0;
  localparam logic [3:0] ROM_CLEAR_KEY = 4'ha;
  // Reset values
  localparam logic RST_IRQ_FLAG = 1'b0;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_PWM_EN = 1'b0;
  localparam logic [3:0] RST_WAKE_CTRL = 4'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_WAKE = 3'b100
  } seq_state_t;
endpackage

// ### rtl/interrupt_wakeup_vector_unit.sv
// Interrupt entry, context save/restore and halt wake-up vectoring unit
//
// Decided for this implementation: the AXI4-Lite slave port.
module interrupt_wakeup_vector_unit
  import irq_wake_pkg::*;
#(
  parameter int unsigned IRQ_PERIOD = IRQ_PERIOD_CYCLES,
  parameter int unsigned WAKE_BASE = WAKE_BASE_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic double_rate_irq_option,
  input wire logic watchdog_option,
  input wire logic [PC_W-1:0] core_next_pc,
  input wire logic [3:0] core_data_page_high,
  input wire logic [3:0] core_memory_address_high,
  input wire logic core_carry_flag,
  input wire logic core_zero_flag,
  input wire logic halt_enter,
  input wire logic return_from_interrupt,
  input wire logic halt_reset_req,
  input wire logic [7:0] rom_fetch_data,
  output logic pc_load,
  output logic [PC_W-1:0] pc_load_addr,
  output logic core_hold,
  output logic irq_in_service,
  output logic restore_load,
  output logic [PC_W-1:0] saved_pc,
  output logic [3:0] saved_data_page_high,
  output logic [3:0] saved_memory_address_high,
  output logic saved_carry_flag,
  output logic saved_zero_flag,
  output logic flag_write,
  output logic [1:0] flag_write_value,
  output logic pwm_output_enable,
  output logic pwm_sample_load,
  output logic wdt_restart
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset and declarations
  logic rst_n;
  logic [ADDR_W-1:0] awaddr_q;
  logic [3:0] wdata_q;
  logic wstrb_q;
  logic do_write;
  logic wr_en;
  logic [5:0] wr_idx;
  logic wr_status;
  logic wr_ctrl;
  logic wr_wake;
  logic wr_rom;
  logic wr_hit;
  logic [3:0] rd_nib;
  logic rd_hit;
  logic pwm_irq_flag;
  logic global_irq_enable;
  logic irq_pending;
  logic accept;
  logic pwm_tick;
  logic [DIV_W-1:0] irq_period;
  logic wake_timer_enable;
  logic [1:0] wake_timer_period_select;
  logic wake_timer_overflow_flag;
  logic wake_clear;
  logic ms_tick;
  logic [7:0] ms_cnt;
  logic [7:0] ms_period;
  logic wake_ovf;
  seq_state_t state;
  logic [6:0] wait_cnt;
  logic [PC_W-1:0] wake_target;

  reset_sync u_reset_sync (
    .clk(core_clk),
    .arst_n(nrst),
    .rst_n(rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_en = do_write && wstrb_q;
  assign wr_idx = awaddr_q[7:2];
  assign wr_status = wr_en && (wr_idx == IDX_STATUS);
  assign wr_ctrl = wr_en && (wr_idx == IDX_PWM_CTRL);
  assign wr_wake = wr_en && (wr_idx == IDX_WAKE_CTRL);
  assign wr_rom = wr_en && (wr_idx == IDX_ROM_HI);
  assign wr_hit = (wr_idx == IDX_STATUS) || (wr_idx == IDX_PWM_CTRL) ||
                  (wr_idx == IDX_WAKE_CTRL) || (wr_idx == IDX_ROM_HI);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 4'h0;
      wstrb_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata[3:0];
        wstrb_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      // Ready comes back only once the response is queued
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_comb begin
    rd_nib = 4'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr[7:2])
      IDX_STATUS: begin
        rd_nib[STAT_IRQ_BIT] = pwm_irq_flag;
        rd_nib[STAT_CARRY_BIT] = core_carry_flag;
        rd_nib[STAT_ZERO_BIT] = core_zero_flag;
      end
      IDX_PWM_CTRL: begin
        rd_nib[CTRL_IRQ_EN_BIT] = global_irq_enable;
        rd_nib[CTRL_PWM_EN_BIT] = pwm_output_enable;
      end
      IDX_WAKE_CTRL: begin
        rd_nib[WAKE_FLAG_BIT] = wake_timer_overflow_flag;
        rd_nib[WAKE_EN_BIT] = wake_timer_enable;
        rd_nib[WAKE_SEL_HI:WAKE_SEL_LO] = wake_timer_period_select;
      end
      IDX_ROM_HI: begin
        rd_nib = rom_fetch_data[7:4];
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {28'h0, rd_nib};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periodic request source
  // Halving the period doubles the rate without a second divider
  assign irq_period = double_rate_irq_option ? DIV_W'(IRQ_PERIOD / 2)
                                             : DIV_W'(IRQ_PERIOD);

  tick_divider #(
    .CNT_W(DIV_W)
  ) u_irq_div (
    .clk(core_clk),
    .rst_n(rst_n),
    .run(pwm_output_enable),
    .clear(1'b0),
    .period(irq_period),
    .tick(pwm_tick)
  );

  assign pwm_sample_load = pwm_tick;

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_irq_flag <= RST_IRQ_FLAG;
    end else if (pwm_tick) begin
      pwm_irq_flag <= 1'b1;
    end else if (wr_status) begin
      pwm_irq_flag <= wdata_q[STAT_IRQ_BIT];
    end
  end

  // Carry and zero live in the core; writes are passed through
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_write <= 1'b0;
      flag_write_value <= 2'h0;
    end else begin
      flag_write <= wr_status;
      flag_write_value <= {wdata_q[STAT_CARRY_BIT], wdata_q[STAT_ZERO_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and interrupt acceptance
  assign accept = irq_pending && global_irq_enable && pwm_irq_flag &&
                  !irq_in_service && (state == ST_RUN) && !halt_enter;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending <= 1'b0;
    end else begin
      irq_pending <= global_irq_enable && pwm_irq_flag && !irq_in_service &&
                     (state == ST_RUN);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable <= RST_IRQ_EN;
    end else if (accept) begin
      global_irq_enable <= 1'b0;
    end else if (return_from_interrupt && irq_in_service) begin
      global_irq_enable <= 1'b1;
    end else if (wr_ctrl) begin
      global_irq_enable <= wdata_q[CTRL_IRQ_EN_BIT];
    end
  end

  // Halt turns the PWM output off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_output_enable <= RST_PWM_EN;
    end else if (halt_enter && (state == ST_RUN)) begin
      pwm_output_enable <= 1'b0;
    end else if (wr_ctrl) begin
      pwm_output_enable <= wdata_q[CTRL_PWM_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Context save and restore
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      saved_pc <= '0;
      saved_data_page_high <= 4'h0;
      saved_memory_address_high <= 4'h0;
      saved_carry_flag <= 1'b0;
      saved_zero_flag <= 1'b0;
    end else if (accept) begin
      saved_pc <= core_next_pc;
      saved_data_page_high <= core_data_page_high;
      saved_memory_address_high <= core_memory_address_high;
      saved_carry_flag <= core_carry_flag;
      saved_zero_flag <= core_zero_flag;
    end
  end

  // One save set only, so a second entry waits for the return
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_in_service <= 1'b0;
      restore_load <= 1'b0;
    end else begin
      restore_load <= return_from_interrupt && irq_in_service;
      if (accept) begin
        irq_in_service <= 1'b1;
      end else if (return_from_interrupt) begin
        irq_in_service <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up timer
  assign wake_clear = wr_rom && (wdata_q == ROM_CLEAR_KEY);

  tick_divider #(
    .CNT_W(DIV_W)
  ) u_wake_div (
    .clk(core_clk),
    .rst_n(rst_n),
    .run(wake_timer_enable),
    .clear(wake_clear),
    .period(DIV_W'(WAKE_BASE)),
    .tick(ms_tick)
  );

  always_comb begin
    unique case (wake_timer_period_select)
      2'b00: ms_period = WAKE_MS_SEL0;
      2'b01: ms_period = WAKE_MS_SEL1;
      2'b10: ms_period = WAKE_MS_SEL2;
      2'b11: ms_period = WAKE_MS_SEL3;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= 8'h0;
      wake_ovf <= 1'b0;
    end else if (wake_clear || !wake_timer_enable) begin
      ms_cnt <= 8'h0;
      wake_ovf <= 1'b0;
    end else if (ms_tick && (ms_cnt >= ms_period - 8'h01)) begin
      ms_cnt <= 8'h0;
      wake_ovf <= 1'b1;
    end else begin
      ms_cnt <= ms_tick ? ms_cnt + 8'h01 : ms_cnt;
      wake_ovf <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_timer_enable <= RST_WAKE_CTRL[WAKE_EN_BIT];
      wake_timer_period_select <= RST_WAKE_CTRL[WAKE_SEL_HI:WAKE_SEL_LO];
    end else if (wr_wake) begin
      wake_timer_enable <= wdata_q[WAKE_EN_BIT];
      wake_timer_period_select <= wdata_q[WAKE_SEL_HI:WAKE_SEL_LO];
    end
  end

  // Writing 1 leaves the flag alone; only a 0 clears it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_timer_overflow_flag <= RST_WAKE_CTRL[WAKE_FLAG_BIT];
    end else if (wake_ovf) begin
      wake_timer_overflow_flag <= 1'b1;
    end else if (wr_wake && !wdata_q[WAKE_FLAG_BIT]) begin
      wake_timer_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_restart <= 1'b0;
    end else begin
      wdt_restart <= wr_rom && watchdog_option;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: run, halt, stable-clock wait
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
      wait_cnt <= 7'h0;
      wake_target <= VEC_RESET;
      pc_load <= 1'b0;
      pc_load_addr <= VEC_RESET;
      core_hold <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      unique case (state)
        ST_RUN: begin
          if (halt_enter) begin
            state <= ST_HALT;
            core_hold <= 1'b1;
            pc_load <= 1'b1;
            pc_load_addr <= VEC_WAKE;
          end else if (accept) begin
            pc_load <= 1'b1;
            pc_load_addr <= VEC_IRQ;
          end
        end
        ST_HALT: begin
          wait_cnt <= 7'h0;
          if (halt_reset_req) begin
            state <= ST_WAKE;
            wake_target <= VEC_RESET;
          end else if (wake_ovf) begin
            state <= ST_WAKE;
            wake_target <= VEC_WAKE;
          end
        end
        ST_WAKE: begin
          if (halt_reset_req) begin
            wake_target <= VEC_RESET;
          end
          if (wait_cnt == WAKE_STABLE_LAST) begin
            state <= ST_RUN;
            core_hold <= 1'b0;
            pc_load <= 1'b1;
            pc_load_addr <= halt_reset_req ? VEC_RESET : wake_target;
          end else begin
            wait_cnt <= wait_cnt + 7'h01;
          end
        end
      endcase
    end
  end

endmodule // interrupt_wakeup_vector_unit

// ### rtl/reset_sync.sv
// Two-stage release synchroniser for the active-low reset
module reset_sync (
  input wire logic clk,
  input wire logic arst_n,
  output logic rst_n
);
  logic meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      meta <= 1'b1;
      rst_n <= meta;
    end
  end
endmodule // reset_sync

// ### rtl/tick_divider.sv
// Free-running divider giving one-cycle ticks every period cycles
module tick_divider #(
  parameter int unsigned CNT_W = 17
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic clear,
  input wire logic [CNT_W-1:0] period,
  output logic tick
);
  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (clear || !run) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt >= period - 1'b1) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // tick_divider

// ### verification/core_model.sv
// Processor core stand-in: program counter and flag owner
module core_model
  import irq_wake_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_addr,
  input wire logic core_hold,
  input wire logic restore_load,
  input wire logic [PC_W-1:0] saved_pc,
  input wire logic saved_carry_flag,
  input wire logic saved_zero_flag,
  input wire logic flag_write,
  input wire logic [1:0] flag_write_value,
  output logic [PC_W-1:0] core_next_pc,
  output logic [3:0] core_data_page_high,
  output logic [3:0] core_memory_address_high,
  output logic core_carry_flag,
  output logic core_zero_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PC_W-1:0] pc;
  // Context moves every cycle the core is not held, so a stale save shows up
  assign core_next_pc = pc + 13'h001;
  assign core_data_page_high = pc[3:0];
  assign core_memory_address_high = pc[7:4];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pc <= 13'h000;
    end else if (pc_load) begin
      pc <= pc_load_addr;
    end else if (restore_load) begin
      pc <= saved_pc;
    end else if (!core_hold) begin
      pc <= pc + 13'h001;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {core_carry_flag, core_zero_flag} <= 2'h0;
    end else if (restore_load) begin
      {core_carry_flag, core_zero_flag} <= {saved_carry_flag, saved_zero_flag};
    end else if (flag_write) begin
      {core_carry_flag, core_zero_flag} <= flag_write_value;
    end
  end
endmodule // core_model

// ### verification/interrupt_wakeup_vector_unit_tb.sv
// Self-checking bench for the interrupt and wake-up vectoring unit
module interrupt_wakeup_vector_unit_tb
  import irq_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned IRQ_P = 16;
  localparam int unsigned WAKE_B = 20;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rom_fetch_data = 8'h5c;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, halt_enter = 1'h0, halt_reset_req = 1'h0;
  logic double_rate_irq_option = 1'h0, watchdog_option = 1'h0, return_from_interrupt = 1'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, flag_write_value, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [PC_W-1:0] core_next_pc, pc_load_addr, saved_pc;
  logic [3:0] core_data_page_high, core_memory_address_high;
  logic [3:0] saved_data_page_high, saved_memory_address_high;
  logic core_carry_flag, core_zero_flag, pc_load, core_hold, irq_in_service, restore_load;
  logic saved_carry_flag, saved_zero_flag, flag_write, pwm_output_enable;
  logic pwm_sample_load, wdt_restart;
  int num_errors = 0, num_checks = 0, cyc = 0, wdt_cnt = 0, irq_cnt = 0, n;
  always #4 core_clk = ~core_clk;
  interrupt_wakeup_vector_unit #(.IRQ_PERIOD(IRQ_P), .WAKE_BASE(WAKE_B))
    i_interrupt_wakeup_vector_unit (.*);
  core_model i_core_model (.*);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Registered outputs read before this edge's updates land
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (wdt_restart === 1'h1) wdt_cnt <= wdt_cnt + 1;
    if (pc_load === 1'h1 && pc_load_addr === VEC_IRQ) irq_cnt <= irq_cnt + 1;
    if (cyc == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ready is registered, so a high level at the falling edge means a handshake next rise
  task automatic wr(input logic [5:0] idx, input logic [3:0] d, input logic [3:0] st);
    @(posedge core_clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {28'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(negedge core_clk); while (s_axi_awready !== 1'h1);
        @(posedge core_clk);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(negedge core_clk); while (s_axi_wready !== 1'h1);
        @(posedge core_clk);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(negedge core_clk); while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    @(posedge core_clk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [5:0] idx);
    @(posedge core_clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge core_clk); while (s_axi_arready !== 1'h1);
    @(posedge core_clk);
    s_axi_arvalid <= 1'h0;
    do @(negedge core_clk); while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge core_clk);
    s_axi_rready <= 1'h0;
  endtask
  // Selector instead of a reference: a reference may not take a deferred assignment
  task automatic pulse(input bit halt);
    @(posedge core_clk);
    if (halt) begin
      halt_enter <= 1'h1;
    end else begin
      return_from_interrupt <= 1'h1;
    end
    @(posedge core_clk);
    halt_enter <= 1'h0;
    return_from_interrupt <= 1'h0;
  endtask
  task automatic wait_load(output int cnt);
    cnt = 0;
    do begin
      @(negedge core_clk);
      cnt++;
    end while (pc_load !== 1'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdr(IDX_STATUS);
    chk("status", 32'h0, rd);
    rdr(IDX_PWM_CTRL);
    chk("control", 32'h0, rd);
    rdr(IDX_WAKE_CTRL);
    chk("wake ctrl", 32'h0, rd);
    rdr(IDX_ROM_HI);
    chk("rom nibble", 32'h5, rd);
    rdr(6'h15);
    chk("unmapped read", RESP_DECERR, rs);
    wr(6'h15, 4'hf, 4'h1);
    chk("unmapped write", RESP_DECERR, rs);
    wr(IDX_STATUS, 4'h2, 4'h1);
    rdr(IDX_STATUS);
    chk("status flags", 32'h2, rd);
  endtask
  task automatic t_rate();
    int a;
    for (int d = 0; d < 2; d++) begin
      @(posedge core_clk);
      double_rate_irq_option <= 1'(d);
      wr(IDX_PWM_CTRL, 4'h1, 4'h1);
      do @(negedge core_clk); while (pwm_sample_load !== 1'h1);
      a = cyc;
      @(negedge core_clk);
      do @(negedge core_clk); while (pwm_sample_load !== 1'h1);
      chk("request period", IRQ_P >> d, cyc - a);
    end
    wr(IDX_PWM_CTRL, 4'h0, 4'h1);
  endtask
  task automatic t_irq();
    int a;
    a = irq_cnt;
    wr(IDX_PWM_CTRL, 4'h1, 4'h1);
    repeat (40) @(posedge core_clk);
    chk("held request", a, irq_cnt);
    rdr(IDX_STATUS);
    chk("request flag", 32'h6, rd);
    wr(IDX_PWM_CTRL, 4'h3, 4'h1);
    repeat (3) @(negedge core_clk);
    chk("accepted", a + 1, irq_cnt);
    chk("in service", 1, irq_in_service);
    rdr(IDX_PWM_CTRL);
    chk("enable cleared", 32'h1, rd);
    rdr(IDX_STATUS);
    chk("flag kept", 32'h6, rd);
    wr(IDX_PWM_CTRL, 4'h3, 4'h1);
    repeat (30) @(posedge core_clk);
    chk("nested", a + 1, irq_cnt);
    wr(IDX_PWM_CTRL, 4'h0, 4'h1);
    wr(IDX_STATUS, 4'h2, 4'h1);
    pulse(1'h0);
    rdr(IDX_PWM_CTRL);
    chk("enable set", 32'h2, rd);
    chk("left service", 0, irq_in_service);
    wr(IDX_PWM_CTRL, 4'h0, 4'h1);
    chk("no reentry", a + 1, irq_cnt);
  endtask
  task automatic t_wake();
    int t[4] = '{1, 16, 64, 128};
    for (int s = 0; s < 4; s++) begin
      wr(IDX_WAKE_CTRL, 4'h4 | 4'(s), 4'h1);
      // Late clear, so a clear that fails moves the wake time out of range
      repeat (40) @(posedge core_clk);
      wr(IDX_ROM_HI, ROM_CLEAR_KEY, 4'h1);
      pulse(1'h1);
      wait_load(n);
      wait_load(n);
      chk("wake vector", VEC_WAKE, pc_load_addr);
      chk("wake time", 1, n >= (t[s] - 1) * WAKE_B + 50 && n <= t[s] * WAKE_B + 70);
      rdr(IDX_WAKE_CTRL);
      chk("overflow flag", 4'hc | 4'(s), rd);
      wr(IDX_WAKE_CTRL, 4'h0, 4'h1);
    end
    pulse(1'h1);
    wait_load(n);
    n = 0;
    repeat (400) begin
      @(negedge core_clk);
      if (core_hold !== 1'h1) n++;
    end
    chk("timer off", 0, n);
    @(posedge core_clk);
    halt_reset_req <= 1'h1;
    wait_load(n);
    chk("reset vector", VEC_RESET, pc_load_addr);
    chk("reset delay", 1, n >= 64 && n <= 70);
    @(posedge core_clk);
    halt_reset_req <= 1'h0;
  endtask
  task automatic t_wdt();
    int a;
    for (int o = 0; o < 2; o++) begin
      @(posedge core_clk);
      watchdog_option <= 1'(o);
      a = wdt_cnt;
      wr(IDX_ROM_HI, 4'h3, 4'h1);
      wr(IDX_ROM_HI, 4'h3, 4'h0);
      chk("masked write", RESP_OKAY, rs);
      repeat (2) @(posedge core_clk);
      chk("restarts", o, wdt_cnt - a);
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_rate();
    t_irq();
    t_wake();
    t_wdt();
    report_and_stop();
  end
endmodule // interrupt_wakeup_vector_unit_tb

// ### verification/irq_wake_sva.sv
// Assertion checker for the interrupt and wake-up vectoring unit
module irq_wake_sva
  import irq_wake_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [PC_W-1:0] core_next_pc,
  input wire logic [3:0] core_data_page_high,
  input wire logic [3:0] core_memory_address_high,
  input wire logic core_carry_flag,
  input wire logic halt_enter,
  input wire logic return_from_interrupt,
  input wire logic watchdog_option,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_addr,
  input wire logic core_hold,
  input wire logic irq_in_service,
  input wire logic restore_load,
  input wire logic [PC_W-1:0] saved_pc,
  input wire logic [3:0] saved_data_page_high,
  input wire logic [3:0] saved_memory_address_high,
  input wire logic saved_carry_flag,
  input wire logic pwm_output_enable,
  input wire logic pwm_sample_load,
  input wire logic wdt_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_entry;
    pc_load && pc_load_addr == VEC_IRQ;
  endsequence
  sequence s_release;
    pc_load && !core_hold;
  endsequence
  property p_entry_vec;
    $rose(irq_in_service) |-> s_entry;
  endproperty
  a_entry_vec: assert property (p_entry_vec) else $error("entry without irq vector");
  property p_ctx_save;
    $rose(irq_in_service) |-> saved_pc == $past(core_next_pc)
      && saved_data_page_high == $past(core_data_page_high)
      && saved_memory_address_high == $past(core_memory_address_high)
      && saved_carry_flag == $past(core_carry_flag);
  endproperty
  a_ctx_save: assert property (p_ctx_save) else $error("context not saved");
  property p_return;
    irq_in_service && return_from_interrupt |=> restore_load && !irq_in_service;
  endproperty
  a_return: assert property (p_return) else $error("return did not restore");
  property p_no_nest;
    $past(irq_in_service) && irq_in_service |-> !(pc_load && pc_load_addr == VEC_IRQ);
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("nested entry");
  property p_halt;
    halt_enter |=> core_hold && pc_load && pc_load_addr == VEC_WAKE && !pwm_output_enable;
  endproperty
  a_halt: assert property (p_halt) else $error("halt entry wrong");
  // Hold covers halt plus the stable-clock wait, so 64 back it was set
  property p_wait;
    $fell(core_hold) |-> s_release ##0 $past(core_hold, 64);
  endproperty
  a_wait: assert property (p_wait) else $error("wake wait too short");
  property p_rst_vec;
    $fell(core_hold) |-> pc_load_addr == VEC_WAKE || pc_load_addr == VEC_RESET;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("release vector wrong");
  // Bound holds for request periods of 8 cycles or more
  property p_rate;
    pwm_sample_load |=> !pwm_sample_load [*7];
  endproperty
  a_rate: assert property (p_rate) else $error("requests too close");
  property p_wdt;
    wdt_restart |-> watchdog_option;
  endproperty
  a_wdt: assert property (p_wdt) else $error("restart without option");
endmodule // irq_wake_sva

bind interrupt_wakeup_vector_unit irq_wake_sva i_irq_wake_sva (.*);
